// *** design/dtp_prescaler.sv ***
// ripple-free binary prescaler with one tick tap per power of two
`timescale 1ns/10ps
module dtp_prescaler #(
  parameter int W = 10
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // control
  input wire logic clear,
  input wire logic tick_in,
  // taps: taps[k] pulses once every 2**k input ticks
  output logic [W:0] taps
);

  logic [W-1:0] cnt_r;

  // ==========================================================
  // divider chain
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      cnt_r <= '0;
    else if (clear)
      cnt_r <= '0;
    else if (tick_in)
      cnt_r <= cnt_r + 1'b1;
  end

  assign taps[0] = tick_in & ~clear;

  genvar k;
  generate
    for (k = 1; k <= W; k++)
    begin : g_tap
      assign taps[k] = tick_in & ~clear & (&cnt_r[k-1:0]);
    end
  endgenerate

endmodule : dtp_prescaler

// *** design/dtp_timer_core.sv ***
// two 8-bit timer/counters with prescalers, compare and pwm outputs
// ============================================================
// How it works
// - timer 0 select: stop, 1,8,64,256,1024, pin edges
// - external pin sampled on clk_sys rising edges
// - prescaler clear bit self clears, reads zero
// - timer 0 control bits 7..4 read zero
// - written count resumes on next timer tick
// - timer 1 divides by 1 to 16384
// - timer 1 prescaler clear bit resets prescaler
// - fast select bit picks fast timebase
// - timer 1 writes pass synchronisation stages
// - timer 1 control/compare read back immediately
// - timer 1 count and flags read delayed in async mode
// - async transfer uses two sync stages
// - compare a/b drive outputs and flags
// - top compare holds maximum count
// - wrap flag on ff->00 or top->00
// - inverted outputs off in normal mode
// - pwm counts to top then restarts
// - two pwm channels, non-overlapping complements
// - flags clear by ack or write one
// - clear-on-top resets counter after top match
// - count write lands after 1 or 2 cycles
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
module dtp_timer_core
  import dtp_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // register port
  input wire dtp_pkg::dtp_bus_req_t bus_req,
  output logic [dtp_pkg::DATA_W-1:0] rdata,
  // timebase pins
  input wire logic tmr0_ext_input,
  input wire logic fast_periph_timebase,
  // interrupt handshake with the cpu
  input wire logic irq_global_en,
  input wire logic [3:0] irq_ack,
  output logic [3:0] irq_req,
  // compare outputs, index 0 is channel a, 1 is channel b
  output logic [1:0] cmp_out,
  output logic [1:0] cmp_out_n,
  output logic [1:0] cmp_out_conn,
  output logic [1:0] cmp_out_n_conn
);

  import dtp_pkg::*;

  // ==========================================================
  // decode helpers
  function automatic logic is_t1_reg(input logic [ADDR_W-1:0] a);
    is_t1_reg = (a == OFS_T1_CTL_A) || (a == OFS_T1_CTL_B) ||
                (a == OFS_T1_CNT) || (a == OFS_CMP_A) ||
                (a == OFS_CMP_B) || (a == OFS_TOP) || (a == OFS_FLAG);
  endfunction : is_t1_reg

  function automatic logic cmp_action(input logic [1:0] com,
                                      input logic cur);
    unique case (dtp_com_t'(com))
      COM_OFF: cmp_action = cur;
      COM_TOGGLE: cmp_action = ~cur;
      COM_CLEAR: cmp_action = 1'b0;
      COM_SET: cmp_action = 1'b1;
    endcase
  endfunction : cmp_action

  logic wr_hit;
  assign wr_hit = bus_req.wr;

  // ==========================================================
  // pin synchronisers
  logic t0_s1_r, t0_s2_r, t0_s3_r;
  logic pck_s1_r, pck_s2_r, pck_s3_r;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      t0_s1_r <= 1'b0;
      t0_s2_r <= 1'b0;
      t0_s3_r <= 1'b0;
    end
    else
    begin
      t0_s1_r <= tmr0_ext_input;
      t0_s2_r <= t0_s1_r;
      t0_s3_r <= t0_s2_r;
    end
  end

  // the fast timebase is seen as edges on clk_sys; it only works while
  // that clock stays below half of clk_sys
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pck_s1_r <= 1'b0;
      pck_s2_r <= 1'b0;
      pck_s3_r <= 1'b0;
    end
    else
    begin
      pck_s1_r <= fast_periph_timebase;
      pck_s2_r <= pck_s1_r;
      pck_s3_r <= pck_s2_r;
    end
  end

  logic t0_rise, t0_fall, pck_rise;
  assign t0_rise = t0_s2_r & ~t0_s3_r;
  assign t0_fall = ~t0_s2_r & t0_s3_r;
  assign pck_rise = pck_s2_r & ~pck_s3_r;

  // ==========================================================
  // cpu side registers
  dtp_t0_ctl_t t0_ctl_r;
  dtp_ctl_a_t ctl_a_r;
  dtp_ctl_b_t ctl_b_r;
  logic [7:0] cmp_a_r, cmp_b_r, top_r, pll_r, mask_r, t0_cnt_r;
  logic t0_psc_clr;

  assign t0_psc_clr = wr_hit && bus_req.addr == OFS_T0_CTL &&
                      bus_req.wdata[3];

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      t0_ctl_r <= '0;
      ctl_a_r <= '0;
      ctl_b_r <= '0;
      cmp_a_r <= RST_BYTE;
      cmp_b_r <= RST_BYTE;
      top_r <= CNT_MAX;
      pll_r <= RST_BYTE;
      mask_r <= RST_BYTE;
    end
    else if (wr_hit)
    begin
      unique case (bus_req.addr)
        OFS_T0_CTL: t0_ctl_r <= dtp_t0_ctl_t'(bus_req.wdata &
                                  T0_CTL_RD_MASK);
        OFS_T1_CTL_A: ctl_a_r <= dtp_ctl_a_t'(bus_req.wdata &
                                  T1_CTL_A_RD_MASK);
        OFS_T1_CTL_B: ctl_b_r <= dtp_ctl_b_t'(bus_req.wdata &
                                  T1_CTL_B_RD_MASK);
        OFS_CMP_A: cmp_a_r <= bus_req.wdata;
        OFS_CMP_B: cmp_b_r <= bus_req.wdata;
        OFS_TOP: top_r <= bus_req.wdata;
        OFS_PLL: pll_r <= bus_req.wdata & PLL_RD_MASK;
        OFS_MASK: mask_r <= bus_req.wdata & FLAG_RD_MASK;
        default: ;
      endcase
    end
  end

  logic async_mode;
  assign async_mode = pll_r[FAST_TB_BIT];

  // ==========================================================
  // timer 0 prescaler and counter
  logic [T0_PSC_W:0] t0_taps;
  logic t0_tick, t0_wrap;

  dtp_prescaler #(.W(T0_PSC_W)) u_t0_psc (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .clear(t0_psc_clr),
    .tick_in(1'b1),
    .taps(t0_taps)
  );

  always_comb
  begin
    unique case (dtp_t0_cs_t'(t0_ctl_r.cs))
      T0_STOP: t0_tick = 1'b0;
      T0_DIV1: t0_tick = t0_taps[0];
      T0_DIV8: t0_tick = t0_taps[T0_TAP_DIV8];
      T0_DIV64: t0_tick = t0_taps[T0_TAP_DIV64];
      T0_DIV256: t0_tick = t0_taps[T0_TAP_DIV256];
      T0_DIV1024: t0_tick = t0_taps[T0_TAP_DIV1024];
      T0_EXT_FALL: t0_tick = t0_fall;
      T0_EXT_RISE: t0_tick = t0_rise;
    endcase
  end

  logic t0_cnt_wr;
  assign t0_cnt_wr = wr_hit && bus_req.addr == OFS_T0_CNT;
  assign t0_wrap = t0_tick && !t0_cnt_wr && t0_cnt_r == CNT_MAX;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      t0_cnt_r <= RST_BYTE;
    else if (t0_cnt_wr)
      t0_cnt_r <= bus_req.wdata;
    else if (t0_tick)
      t0_cnt_r <= t0_cnt_r + 1'b1;
  end

  // ==========================================================
  // timer 1 input synchronisation: one stage in sync mode, two in async
  dtp_sync_wr_t sync1_r, sync2_r, applied;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r.valid <= wr_hit && is_t1_reg(bus_req.addr);
      sync1_r.addr <= bus_req.addr;
      sync1_r.data <= bus_req.wdata;
      sync2_r <= sync1_r;
    end
  end

  assign applied = async_mode ? sync2_r : sync1_r;

  function automatic logic app_hit(input dtp_sync_wr_t s,
                                   input logic [ADDR_W-1:0] a);
    app_hit = s.valid && s.addr == a;
  endfunction : app_hit

  dtp_ctl_a_t ctl_a_si_r;
  dtp_ctl_b_t ctl_b_si_r;
  logic [7:0] cmp_a_si_r, cmp_b_si_r, top_si_r;
  logic t1_psc_clr;
  logic [1:0] force_evt;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ctl_a_si_r <= '0;
      ctl_b_si_r <= '0;
      cmp_a_si_r <= RST_BYTE;
      cmp_b_si_r <= RST_BYTE;
      top_si_r <= CNT_MAX;
    end
    else if (applied.valid)
    begin
      unique case (applied.addr)
        OFS_T1_CTL_A: ctl_a_si_r <= dtp_ctl_a_t'(applied.data &
                                      T1_CTL_A_RD_MASK);
        OFS_T1_CTL_B: ctl_b_si_r <= dtp_ctl_b_t'(applied.data &
                                      T1_CTL_B_RD_MASK);
        OFS_CMP_A: cmp_a_si_r <= applied.data;
        OFS_CMP_B: cmp_b_si_r <= applied.data;
        OFS_TOP: top_si_r <= applied.data;
        default: ;
      endcase
    end
  end

  // self-clearing strobes: they live for the single applying cycle
  assign t1_psc_clr = app_hit(applied, OFS_T1_CTL_B) &&
                      applied.data[6];
  assign force_evt[0] = app_hit(applied, OFS_T1_CTL_A) &&
                        applied.data[3] && !applied.data[1];
  assign force_evt[1] = app_hit(applied, OFS_T1_CTL_A) &&
                        applied.data[2] && !applied.data[0];

  // ==========================================================
  // timer 1 prescaler and counter
  logic [T1_PSC_W:0] t1_taps;
  logic t1_tick, t1_cnt_wr, t1_hit_top, t1_clear_en, t1_wrap;
  logic [7:0] t1_cnt_r, t1_nxt;
  logic [1:0] cmp_match;

  dtp_prescaler #(.W(T1_PSC_W)) u_t1_psc (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .clear(t1_psc_clr),
    .tick_in(async_mode ? pck_rise : 1'b1),
    .taps(t1_taps)
  );

  // code n selects tap n-1, so code 15 divides by 16384
  assign t1_tick = (ctl_b_si_r.cs != 4'h0) &&
                   t1_taps[ctl_b_si_r.cs - 4'h1];

  assign t1_cnt_wr = app_hit(applied, OFS_T1_CNT);
  assign t1_hit_top = t1_cnt_r == top_si_r;
  assign t1_clear_en = ctl_b_si_r.clear_on_top | ctl_a_si_r.pwm_a |
                       ctl_a_si_r.pwm_b;
  assign t1_nxt = (t1_clear_en && t1_hit_top) ? RST_BYTE :
                  t1_cnt_r + 1'b1;
  assign t1_wrap = t1_tick && !t1_cnt_wr &&
                   (t1_cnt_r == CNT_MAX ||
                    (t1_clear_en && t1_hit_top));
  assign cmp_match[0] = t1_tick && !t1_cnt_wr &&
                        t1_nxt == cmp_a_si_r;
  assign cmp_match[1] = t1_tick && !t1_cnt_wr &&
                        t1_nxt == cmp_b_si_r;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      t1_cnt_r <= RST_BYTE;
    else if (t1_cnt_wr)
      t1_cnt_r <= applied.data;
    else if (t1_tick)
      t1_cnt_r <= t1_nxt;
  end

  // ==========================================================
  // flags: hardware set wins over any clear in the same cycle
  logic [7:0] flags_r, flag_set, flag_clr, flags_so_r;
  logic [7:0] t1_cnt_so_r;

  always_comb
  begin
    flag_set = RST_BYTE;
    flag_clr = RST_BYTE;
    flag_set[FLAG_CMP_A] = cmp_match[0];
    flag_set[FLAG_CMP_B] = cmp_match[1];
    flag_set[FLAG_T1_WRAP] = t1_wrap;
    flag_set[FLAG_T0_WRAP] = t0_wrap;
    if (app_hit(applied, OFS_FLAG))
    begin
      flag_clr[FLAG_CMP_A] = applied.data[FLAG_CMP_A];
      flag_clr[FLAG_CMP_B] = applied.data[FLAG_CMP_B];
      flag_clr[FLAG_T1_WRAP] = applied.data[FLAG_T1_WRAP];
    end
    if (wr_hit && bus_req.addr == OFS_FLAG)
      flag_clr[FLAG_T0_WRAP] = bus_req.wdata[FLAG_T0_WRAP];
    flag_clr[FLAG_CMP_A] = flag_clr[FLAG_CMP_A] | irq_ack[IRQ_CMP_A];
    flag_clr[FLAG_CMP_B] = flag_clr[FLAG_CMP_B] | irq_ack[IRQ_CMP_B];
    flag_clr[FLAG_T1_WRAP] = flag_clr[FLAG_T1_WRAP] |
                             irq_ack[IRQ_T1_WRAP];
    flag_clr[FLAG_T0_WRAP] = flag_clr[FLAG_T0_WRAP] |
                             irq_ack[IRQ_T0_WRAP];
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      flags_r <= RST_BYTE;
    else
      flags_r <= ((flags_r & ~flag_clr) | flag_set) & FLAG_RD_MASK;
  end

  // output synchronisation stage seen only by reads in async mode
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      flags_so_r <= RST_BYTE;
      t1_cnt_so_r <= RST_BYTE;
    end
    else
    begin
      flags_so_r <= flags_r;
      t1_cnt_so_r <= t1_cnt_r;
    end
  end

  logic [7:0] flags_seen;
  always_comb
  begin
    flags_seen = async_mode ? flags_so_r : flags_r;
    flags_seen[FLAG_T0_WRAP] = flags_r[FLAG_T0_WRAP];
  end

  logic [7:0] flags_en;
  assign flags_en = flags_r & mask_r & {8{irq_global_en}};
  assign irq_req = {flags_en[FLAG_CMP_A], flags_en[FLAG_CMP_B],
                    flags_en[FLAG_T1_WRAP], flags_en[FLAG_T0_WRAP]};

  // ==========================================================
  // compare and pwm channels
  logic [1:0][1:0] ch_com;
  logic [1:0] ch_pwm;
  assign ch_com = {ctl_a_si_r.com_b, ctl_a_si_r.com_a};
  assign ch_pwm = {ctl_a_si_r.pwm_b, ctl_a_si_r.pwm_a};

  genvar c;
  generate
    for (c = 0; c < 2; c++)
    begin : g_ch
      logic lvl_r, lvl_d_r, out_r, out_n_r;

      // pwm level: high from restart, low from duty match
      always_ff @(posedge clk_sys or negedge nrst)
      begin
        if (!nrst)
        begin
          lvl_r <= 1'b0;
          lvl_d_r <= 1'b0;
        end
        else
        begin
          if (cmp_match[c])
            lvl_r <= 1'b0;
          else if (t1_wrap)
            lvl_r <= 1'b1;
          lvl_d_r <= lvl_r;
        end
      end

      // true and inverted outputs each wait one extra cycle before rising
      // but drop at once, so they never overlap
      always_ff @(posedge clk_sys or negedge nrst)
      begin
        if (!nrst)
        begin
          out_r <= 1'b0;
          out_n_r <= 1'b0;
        end
        else if (ch_pwm[c])
        begin
          out_r <= lvl_r & lvl_d_r;
          out_n_r <= ~lvl_r & ~lvl_d_r;
        end
        else
        begin
          if (cmp_match[c] || force_evt[c])
            out_r <= cmp_action(ch_com[c], out_r);
          out_n_r <= 1'b0;
        end
      end

      assign cmp_out[c] = out_r;
      assign cmp_out_n[c] = out_n_r;
      assign cmp_out_conn[c] = ch_com[c] != COM_OFF;
      assign cmp_out_n_conn[c] = ch_pwm[c] &&
                                 ch_com[c] == COM_TOGGLE;
    end
  endgenerate

  // ==========================================================
  // read port: data valid in the cycle after the read strobe
  logic [7:0] rdata_r;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      rdata_r <= RST_BYTE;
    else if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        OFS_T0_CTL: rdata_r <= t0_ctl_r & T0_CTL_RD_MASK;
        OFS_T0_CNT: rdata_r <= t0_cnt_r;
        OFS_T1_CTL_A: rdata_r <= ctl_a_r & T1_CTL_A_RD_MASK;
        OFS_T1_CTL_B: rdata_r <= ctl_b_r & T1_CTL_B_RD_MASK;
        OFS_T1_CNT: rdata_r <= async_mode ? t1_cnt_so_r :
                               t1_cnt_r;
        OFS_CMP_A: rdata_r <= cmp_a_r;
        OFS_CMP_B: rdata_r <= cmp_b_r;
        OFS_TOP: rdata_r <= top_r;
        OFS_PLL: rdata_r <= pll_r;
        OFS_FLAG: rdata_r <= flags_seen;
        OFS_MASK: rdata_r <= mask_r;
        default: rdata_r <= RST_BYTE;
      endcase
    end
  end

  assign rdata = rdata_r;

endmodule : dtp_timer_core

// *** inc/dtp_pkg.sv ***
// constants, field layouts and carriers for the dual timer/prescaler core
package dtp_pkg;

  // ==========================================================
  // bus and data widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_T1_CTL_A = 8'h30;
  localparam logic [7:0] OFS_T1_CTL_B = 8'h2F;
  localparam logic [7:0] OFS_T1_CNT = 8'h2E;
  localparam logic [7:0] OFS_CMP_A = 8'h2D;
  localparam logic [7:0] OFS_CMP_B = 8'h2C;
  localparam logic [7:0] OFS_TOP = 8'h2B;
  localparam logic [7:0] OFS_PLL = 8'h29;
  localparam logic [7:0] OFS_T0_CTL = 8'h33;
  localparam logic [7:0] OFS_T0_CNT = 8'h32;
  localparam logic [7:0] OFS_FLAG = 8'h38;
  localparam logic [7:0] OFS_MASK = 8'h39;

  // ==========================================================
  // reset values, read masks, bit positions
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] T0_CTL_RD_MASK = 8'h07;
  localparam logic [7:0] T1_CTL_A_RD_MASK = 8'hF3;
  localparam logic [7:0] T1_CTL_B_RD_MASK = 8'h8F;
  localparam logic [7:0] FLAG_RD_MASK = 8'h66;
  localparam logic [7:0] PLL_RD_MASK = 8'h04;
  localparam int FAST_TB_BIT = 2;
  localparam int FLAG_CMP_A = 6;
  localparam int FLAG_CMP_B = 5;
  localparam int FLAG_T1_WRAP = 2;
  localparam int FLAG_T0_WRAP = 1;
  localparam int IRQ_CMP_A = 3;
  localparam int IRQ_CMP_B = 2;
  localparam int IRQ_T1_WRAP = 1;
  localparam int IRQ_T0_WRAP = 0;

  // ==========================================================
  // prescaler sizes and timer 0 taps (tap k = divide by 2**k)
  localparam int T0_PSC_W = 10;
  localparam int T1_PSC_W = 14;
  localparam int T0_TAP_DIV8 = 3;
  localparam int T0_TAP_DIV64 = 6;
  localparam int T0_TAP_DIV256 = 8;
  localparam int T0_TAP_DIV1024 = 10;

  // ==========================================================
  // enumerations
  typedef enum logic [2:0] {
    T0_STOP = 3'b000,
    T0_DIV1 = 3'b001,
    T0_DIV8 = 3'b010,
    T0_DIV64 = 3'b011,
    T0_DIV256 = 3'b100,
    T0_DIV1024 = 3'b101,
    T0_EXT_FALL = 3'b110,
    T0_EXT_RISE = 3'b111
  } dtp_t0_cs_t;

  typedef enum logic [1:0] {
    COM_OFF = 2'b00,
    COM_TOGGLE = 2'b01,
    COM_CLEAR = 2'b10,
    COM_SET = 2'b11
  } dtp_com_t;

  // ==========================================================
  // register layouts and carriers
  typedef struct packed {
    logic [1:0] com_a;
    logic [1:0] com_b;
    logic force_a;
    logic force_b;
    logic pwm_a;
    logic pwm_b;
  } dtp_ctl_a_t;

  typedef struct packed {
    logic clear_on_top;
    logic psc_clr;
    logic [1:0] rsvd;
    logic [3:0] cs;
  } dtp_ctl_b_t;

  typedef struct packed {
    logic [3:0] rsvd;
    logic psc_clr;
    logic [2:0] cs;
  } dtp_t0_ctl_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dtp_bus_req_t;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } dtp_sync_wr_t;

endpackage : dtp_pkg

// *** testbench/dtp_pin_model.sv ***
// pin-side model: timer 0 clock pin and free-running fast timebase
`timescale 1ns/10ps
module dtp_pin_model (
  // pins towards the core
  output logic tmr0_ext_input,
  output logic fast_periph_timebase
);
  // offset keeps the fast timebase edges off the system clock edges
  initial
  begin
    tmr0_ext_input = 1'b0;
    fast_periph_timebase = 1'b0;
    #7;
    forever #75 fast_periph_timebase = ~fast_periph_timebase;
  end

  // edges spaced three system clocks apart, never closer
  task automatic pulses(input int n);
    #3;
    repeat (n)
    begin
      #150 tmr0_ext_input = 1'b1;
      #150 tmr0_ext_input = 1'b0;
    end
  endtask : pulses
endmodule : dtp_pin_model

// *** testbench/dtp_tc_chk.sv ***
// port-level assertion checker for the dual timer core
`timescale 1ns/10ps
module dtp_tc_chk
  import dtp_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // register port
  input wire dtp_pkg::dtp_bus_req_t bus_req,
  input wire logic [7:0] rdata,
  // interrupts and compare outputs
  input wire logic irq_global_en,
  input wire logic [3:0] irq_req,
  input wire logic [1:0] cmp_out,
  input wire logic [1:0] cmp_out_n,
  input wire logic [1:0] cmp_out_conn,
  input wire logic [1:0] cmp_out_n_conn
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  // ==========================================================
  // shadow of timer 1 control a, kept from bus writes
  dtp_ctl_a_t sh_r;
  logic [7:0] ad;
  logic rd_t0;
  assign ad = bus_req.addr;
  assign rd_t0 = bus_req.rd && ad == OFS_T0_CTL;

  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      sh_r <= '0;
    else if (bus_req.wr && ad == OFS_T1_CTL_A)
      sh_r <= bus_req.wdata;

  // ==========================================================
  // assertions
  a_t0_rsvd_zero: assert property (rd_t0 |=> rdata[7:4] == 4'h0)
    else $error("timer 0 control upper bits read nonzero");
  a_psc_clr_zero: assert property (rd_t0 |=> !rdata[3])
    else $error("timer 0 prescaler clear bit read as one");
  a_cmpa_readback: assert property (
    (bus_req.wr && ad == OFS_CMP_A) ##1 (bus_req.rd && ad == OFS_CMP_A)
    |=> rdata == $past(bus_req.wdata, 2))
    else $error("compare a readback differs from write");
  a_ctla_readback: assert property (
    (bus_req.wr && ad == OFS_T1_CTL_A) ##1 (bus_req.rd && ad == OFS_T1_CTL_A)
    |=> rdata == ($past(bus_req.wdata, 2) & T1_CTL_A_RD_MASK))
    else $error("control a readback differs from write");
  a_top_readback: assert property (
    (bus_req.wr && ad == OFS_TOP) ##1 (bus_req.rd && ad == OFS_TOP)
    |=> rdata == $past(bus_req.wdata, 2))
    else $error("top count readback differs from write");
  a_pll_mask: assert property (
    bus_req.rd && ad == OFS_PLL |=> (rdata & ~PLL_RD_MASK) == 8'h00)
    else $error("pll control unused bits read nonzero");
  a_inv_off_normal: assert property (
    (!sh_r.pwm_a) [*3] |-> !cmp_out_n_conn[0])
    else $error("inverted output a connected in normal mode");
  a_true_conn: assert property (
    $stable(sh_r.com_a) [*3] |-> cmp_out_conn[0] == (sh_r.com_a != 2'b00))
    else $error("output a connection disagrees with mode field");
  a_pwm_no_overlap: assert property (!(|(cmp_out & cmp_out_n)))
    else $error("true and inverted outputs high together");
  a_irq_gate: assert property (|irq_req |-> irq_global_en)
    else $error("interrupt request without global enable");

  c_inv_pwm: cover property (cmp_out_n[0]);
  c_t1_irq: cover property (irq_req[IRQ_T1_WRAP]);
  c_pwm_edge: cover property (cmp_out[0] ##1 !cmp_out[0]);
endmodule : dtp_tc_chk

bind dtp_timer_core dtp_tc_chk chk (.clk_sys(clk_sys), .nrst(nrst),
  .bus_req(bus_req), .rdata(rdata), .irq_global_en(irq_global_en),
  .irq_req(irq_req), .cmp_out(cmp_out), .cmp_out_n(cmp_out_n),
  .cmp_out_conn(cmp_out_conn), .cmp_out_n_conn(cmp_out_n_conn));

// *** testbench/dtp_timer_core_tb_top.sv ***
// self-checking bench for the dual timer core
`timescale 1ns/10ps
module dtp_timer_core_tb_top;
  import dtp_pkg::*;
  typedef struct {
    logic [2:0] cs;
    int cyc;
    logic [7:0] lo;
    logic [7:0] hi;
  } dtp_row_t;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  dtp_bus_req_t bus_req = '0;
  logic [7:0] rdata, v;
  logic tmr0_ext_input, fast_periph_timebase;
  logic irq_global_en = 1'b0;
  logic [3:0] irq_ack = 4'h0;
  logic [3:0] irq_req;
  logic [1:0] cmp_out, cmp_out_n, cmp_out_conn, cmp_out_n_conn;
  int n_errors = 0;
  int checks_done = 0;
  int hi_t, hi_n;
  // ext rows count pin pulses instead of clock cycles
  dtp_row_t rows [8] = '{'{3'h0, 100, 8'h00, 8'h00},
    '{3'h1, 10, 8'h0C, 8'h14}, '{3'h2, 80, 8'h09, 8'h0C},
    '{3'h3, 640, 8'h09, 8'h0C}, '{3'h4, 2560, 8'h09, 8'h0C},
    '{3'h5, 10240, 8'h09, 8'h0C}, '{3'h6, 10, 8'h09, 8'h0C},
    '{3'h7, 10, 8'h09, 8'h0C}};

  always #25 clk_sys = ~clk_sys;

  dtp_timer_core uut (.clk_sys(clk_sys), .nrst(nrst), .bus_req(bus_req),
    .rdata(rdata), .tmr0_ext_input(tmr0_ext_input),
    .fast_periph_timebase(fast_periph_timebase),
    .irq_global_en(irq_global_en), .irq_ack(irq_ack), .irq_req(irq_req),
    .cmp_out(cmp_out), .cmp_out_n(cmp_out_n), .cmp_out_conn(cmp_out_conn),
    .cmp_out_n_conn(cmp_out_n_conn));
  dtp_pin_model pins (.tmr0_ext_input(tmr0_ext_input),
    .fast_periph_timebase(fast_periph_timebase));

  // ==========================================================
  // compares, bus cycles, closing
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic check_range(input logic [7:0] got, input logic [7:0] lo,
      input logic [7:0] hi);
    checks_done++;
    if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1))
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask : check_range

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    bus_req <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_sys);
    bus_req <= '0;
    #1 d = rdata;
  endtask : rd

  // write then read the same place with no gap
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q);
    @(posedge clk_sys);
    bus_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    bus_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_sys);
    bus_req <= '0;
    #1 q = rdata;
  endtask : wr_rd

  task automatic expect_reg(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    rd(a, q);
    check(q, e);
  endtask : expect_reg

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  // ==========================================================
  // tests
  initial
  begin
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    expect_reg(OFS_T1_CTL_A, RST_BYTE);
    expect_reg(OFS_TOP, CNT_MAX);
    expect_reg(OFS_FLAG, RST_BYTE);
    expect_reg(OFS_PLL, RST_BYTE);
    wr(8'h00, 8'hFF);
    expect_reg(8'h00, 8'h00);
    wr(OFS_T0_CTL, 8'hFF);
    expect_reg(OFS_T0_CTL, T0_CTL_RD_MASK);
    $display("test reset values done");
    foreach (rows[i])
    begin
      wr(OFS_T0_CTL, {5'b00001, rows[i].cs});
      wr(OFS_T0_CNT, 8'h00);
      if (rows[i].cs[2:1] == 2'b11)
        pins.pulses(rows[i].cyc);
      else
        repeat (rows[i].cyc) @(posedge clk_sys);
      repeat (4) @(posedge clk_sys);
      wr(OFS_T0_CTL, 8'h00);
      rd(OFS_T0_CNT, v);
      check_range(v, rows[i].lo, rows[i].hi);
    end
    $display("test timer 0 selects done");
    wr(OFS_MASK, 8'h07);
    wr(OFS_T0_CNT, 8'hF0);
    wr(OFS_T0_CTL, 8'h01);
    repeat (30) @(posedge clk_sys);
    wr(OFS_T0_CTL, 8'h00);
    irq_global_en <= 1'b1;
    @(posedge clk_sys);
    #1 check({7'h0, irq_req[IRQ_T0_WRAP]}, 8'h01);
    @(posedge clk_sys);
    irq_ack <= 4'h1;
    @(posedge clk_sys);
    irq_ack <= 4'h0;
    #1 check({7'h0, irq_req[IRQ_T0_WRAP]}, 8'h00);
    $display("test timer 0 wrap done");
    wr(OFS_TOP, 8'h0F);
    wr(OFS_T1_CTL_B, 8'h81);
    repeat (40) @(posedge clk_sys);
    rd(OFS_FLAG, v);
    check(v & 8'h04, 8'h04);
    for (int k = 0; k < 3; k++)
    begin
      rd(OFS_T1_CNT, v);
      check_range(v, 8'h00, 8'h0F);
    end
    check({4'h0, irq_req}, 8'h02);
    wr(OFS_CMP_A, 8'h08);
    wr(OFS_T1_CTL_A, 8'h42);
    repeat (4) @(posedge clk_sys);
    hi_t = 0;
    hi_n = 0;
    repeat (32)
    begin
      @(posedge clk_sys);
      #1 hi_t += int'(cmp_out[0] === 1'b1);
      hi_n += int'(cmp_out_n[0] === 1'b1);
    end
    check({7'h0, cmp_out_n_conn[0]}, 8'h01);
    check_range(hi_t[7:0], 8'h0C, 8'h10);
    check_range(hi_n[7:0], 8'h0C, 8'h10);
    wr(OFS_T1_CTL_A, 8'h80);
    wr(OFS_T1_CTL_B, 8'h00);
    wr(OFS_T1_CTL_A, 8'hB0);
    wr(OFS_T1_CTL_A, 8'hB4);
    repeat (4) @(posedge clk_sys);
    check({7'h0, cmp_out[1]}, 8'h01);
    check({6'h0, cmp_out_conn}, 8'h03);
    check({6'h0, cmp_out_n_conn}, 8'h00);
    wr(OFS_FLAG, 8'h04);
    repeat (3) @(posedge clk_sys);
    rd(OFS_FLAG, v);
    check(v & 8'h04, 8'h00);
    wr(OFS_T1_CNT, 8'h42);
    expect_reg(OFS_T1_CNT, 8'h42);
    $display("test timer 1 sync done");
    wr_rd(OFS_CMP_A, 8'h5A, v);
    check(v, 8'h5A);
    wr_rd(OFS_T1_CTL_A, 8'hFF, v);
    check(v, T1_CTL_A_RD_MASK);
    wr_rd(OFS_TOP, 8'hFF, v);
    check(v, 8'hFF);
    wr(OFS_T1_CTL_A, 8'h00);
    wr(OFS_PLL, 8'h04);
    wr(OFS_T1_CNT, 8'h00);
    wr(OFS_T1_CTL_B, 8'h01);
    repeat (100) @(posedge clk_sys);
    wr(OFS_T1_CTL_B, 8'h00);
    rd(OFS_T1_CNT, v);
    check_range(v, 8'h19, 8'h28);
    $display("test timer 1 async done");
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    expect_reg(OFS_PLL, RST_BYTE);
    $display("test second reset done");
    conclude();
  end

  // hang guard, roughly three times the expected run
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    n_errors++;
    conclude();
  end
endmodule : dtp_timer_core_tb_top
